/* File: hw/ring_gen_pkg.sv */
package ring_gen_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS    = 4;
  localparam int STEP_TIME_NS     = 125000;
  localparam int SAMPLE_TIME_NS   = 1000000;
  localparam int STEP_CYCLES      = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES    = SAMPLE_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_W            = 18;

  // ==========================================================================
  // Direct register addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_IND_DATA_LO = 8'h1C;
  localparam logic [7:0] ADDR_IND_DATA_HI = 8'h1D;
  localparam logic [7:0] ADDR_IND_WRITE   = 8'h1E;
  localparam logic [7:0] ADDR_IND_READ    = 8'h1F;
  localparam logic [7:0] ADDR_RING_CFG    = 8'h22;
  localparam logic [7:0] ADDR_ON_LO       = 8'h30;
  localparam logic [7:0] ADDR_ON_HI       = 8'h31;
  localparam logic [7:0] ADDR_OFF_LO      = 8'h32;
  localparam logic [7:0] ADDR_OFF_HI      = 8'h33;
  localparam logic [7:0] ADDR_LINE_STATE  = 8'h40;
  localparam logic [7:0] ADDR_HIGH_BATT   = 8'h4A;

  // ==========================================================================
  // Indirect register addresses
  // ==========================================================================
  localparam logic [7:0] IND_DC_BIAS      = 8'h06;
  localparam logic [7:0] IND_FREQ         = 8'h07;
  localparam logic [7:0] IND_AMPLITUDE    = 8'h08;
  localparam logic [7:0] IND_PHASE        = 8'h09;
  localparam logic [7:0] IND_HEADROOM     = 8'h1B;

  // ==========================================================================
  // Fields and codes
  // ==========================================================================
  localparam int CFG_SHAPE        = 0;
  localparam int CFG_OFFSET       = 1;
  localparam int CFG_OSC_ON       = 2;
  localparam int CFG_OFF_TIMER    = 3;
  localparam int CFG_ON_TIMER     = 4;
  localparam logic [2:0] LS_RING      = 3'h4;
  localparam logic [2:0] LS_ONHOOK_TX = 3'h2;

  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} phase_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [DIV_W-1:0] step_div;
    logic [DIV_W-1:0] ms_div;
    logic             step_tick;
    logic             ms_tick;
    logic [7:0]       cfg;
    logic [15:0]      on_period;
    logic [15:0]      off_period;
    logic [2:0]       lf;
    logic [5:0]       batt;
    logic [7:0]       ind_lo;
    logic [7:0]       ind_hi;
    logic [7:0]       ind_addr;
    logic [15:0]      bias;
    logic [15:0]      freq;
    logic [15:0]      amp;
    logic [15:0]      phase_seed;
    logic [3:0]       headroom;
    phase_t           phase;
    logic [15:0]      cnt;
    logic [15:0]      y;
    logic [15:0]      y_prev;
    logic [15:0]      half_cnt;
    logic             ramp_down;
    logic [15:0]      sample;
    logic             sample_valid;
    logic [2:0]       line_state;
    logic             ringing;
    logic [7:0]       rdata;
    logic             rvalid;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage : ring_gen_pkg

/* File: hw/ringing_waveform_generator.sv */
`timescale 1ns/1ps
//
// Contract
// - Sine ringing samples update at 1 kHz; trapezoid samples update at the 8 kHz step rate.
// - Sine ringing comes from a two-pole resonator with programmable coefficients.
// - Two cadence timers, ring-on and ring-off, each up to 8 seconds.
// - Cadence timers also move the line into and out of ringing.
// - Writing ringing code to line state enters ringing, first ring immediately.
// - On-timer expiry stops the waveform, line goes to on-hook transmission.
// - Off-timer expiry restarts the waveform and begins the next ring.
// - Alternation continues only while both enables set and ringing selected.
// - Shape select bit 0 cleared gives sine ringing.
// - Phase coefficient is sine start phase, or trapezoid half-period length.
// - Configuration register holds a dc offset add enable bit.
// - Configuration holds on-timer, off-timer and oscillator enable bits.
// - A four-bit common-mode headroom setting covers 0 to 22.5 V.
// - Indirect registers are reached only through direct locations 28 to 31.
// - Shape bit one selects trapezoid: coefficient is a per-sample ramp step.
// - DC offset is added only while the offset enable bit is one.
// - Cadence counts advance in 125 us steps over a 16-bit range.
module ringing_waveform_generator #(
  parameter int STEP_DIV   = ring_gen_pkg::STEP_CYCLES,
  parameter int SAMPLE_DIV = ring_gen_pkg::SAMPLE_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire ring_gen_pkg::reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  output logic [15:0]                ring_sample,
  output logic                       sample_valid,
  output logic                       ringing_active,
  output logic [2:0]                 line_state,
  output logic [3:0]                 cm_headroom,
  output logic [5:0]                 high_battery_setting
);
  import ring_gen_pkg::*;

  state_t             st;
  state_t             next_st;
  logic               ring_sel;
  logic               timers_any;
  logic               run;
  logic [15:0]        wave_now;
  logic [15:0]        offset_now;
  logic signed [31:0] prod;
  logic [15:0]        sine_next;
  logic signed [16:0] ramp_up;
  logic signed [16:0] ramp_dn;
  logic signed [16:0] pos_amp;
  logic signed [16:0] neg_amp;
  logic               sine_step;
  logic               trap_step;
  logic               on_expire;
  logic               off_expire;

  // ==========================================================================
  // Indirect read mux
  // ==========================================================================
  function automatic logic [15:0] ind_read(input state_t s,
                                           input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      IND_DC_BIAS:   v = s.bias;
      IND_FREQ:      v = s.freq;
      IND_AMPLITUDE: v = s.amp;
      IND_PHASE:     v = s.phase_seed;
      IND_HEADROOM:  v = {12'h000, s.headroom};
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction : ind_read

  // ==========================================================================
  // Datapath terms
  // ==========================================================================
  // The oscillator only runs in the ring phase; with no timer enabled the
  // oscillator enable bit gates it directly.
  assign timers_any = st.cfg[CFG_ON_TIMER] | st.cfg[CFG_OFF_TIMER];
  assign run        = (st.phase == PH_ON) &&
                      (timers_any || st.cfg[CFG_OSC_ON]);
  assign wave_now   = run ? st.y : 16'h0000;
  assign offset_now = st.cfg[CFG_OFFSET] ? st.bias : 16'h0000;
  assign prod       = $signed(st.freq) * $signed(st.y);
  // Product is Q15 times sample; bits 29:14 give twice the scaled value.
  assign sine_next  = 16'(prod[29:14] - st.y_prev);
  assign pos_amp    = $signed({1'b0, st.amp});
  assign neg_amp    = -pos_amp;
  assign ramp_up    = $signed({st.y[15], st.y}) + $signed({1'b0, st.freq});
  assign ramp_dn    = $signed({st.y[15], st.y}) - $signed({1'b0, st.freq});
  assign sine_step  = st.ms_tick && run && !st.cfg[CFG_SHAPE];
  assign trap_step  = st.step_tick && run && st.cfg[CFG_SHAPE];
  assign on_expire  = st.step_tick && st.cfg[CFG_ON_TIMER] &&
                      (st.cnt == st.on_period);
  assign off_expire = st.step_tick && st.cfg[CFG_OFF_TIMER] &&
                      (st.cnt == st.off_period);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st              = st;
    next_st.step_tick    = 1'b0;
    next_st.ms_tick      = 1'b0;
    next_st.rvalid       = 1'b0;
    next_st.sample_valid = 1'b0;

    // Dividers for the 125 us cadence step and the 1 ms sample strobe.
    if (st.step_div == DIV_W'(STEP_DIV - 1)) begin
      next_st.step_div  = '0;
      next_st.step_tick = 1'b1;
    end else begin
      next_st.step_div = st.step_div + 1'b1;
    end
    if (st.ms_div == DIV_W'(SAMPLE_DIV - 1)) begin
      next_st.ms_div  = '0;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.ms_div = st.ms_div + 1'b1;
    end

    // Register writes. Indirect words only move through the access window.
    if (reg_req.write) begin
      case (reg_req.addr)
        ADDR_IND_DATA_LO: next_st.ind_lo = reg_req.wdata;
        ADDR_IND_DATA_HI: next_st.ind_hi = reg_req.wdata;
        ADDR_IND_WRITE: begin
          next_st.ind_addr = reg_req.wdata;
          case (reg_req.wdata)
            IND_DC_BIAS:   next_st.bias       = {st.ind_hi, st.ind_lo};
            IND_FREQ:      next_st.freq       = {st.ind_hi, st.ind_lo};
            IND_AMPLITUDE: next_st.amp        = {st.ind_hi, st.ind_lo};
            IND_PHASE:     next_st.phase_seed = {st.ind_hi, st.ind_lo};
            IND_HEADROOM:  next_st.headroom   = st.ind_lo[3:0];
            default: begin
            end
          endcase
        end
        ADDR_IND_READ: begin
          next_st.ind_addr = reg_req.wdata;
          {next_st.ind_hi, next_st.ind_lo} = ind_read(st, reg_req.wdata);
        end
        ADDR_RING_CFG:    next_st.cfg = reg_req.wdata;
        ADDR_ON_LO:       next_st.on_period[7:0]   = reg_req.wdata;
        ADDR_ON_HI:       next_st.on_period[15:8]  = reg_req.wdata;
        ADDR_OFF_LO:      next_st.off_period[7:0]  = reg_req.wdata;
        ADDR_OFF_HI:      next_st.off_period[15:8] = reg_req.wdata;
        ADDR_LINE_STATE:  next_st.lf   = reg_req.wdata[2:0];
        ADDR_HIGH_BATT:   next_st.batt = reg_req.wdata[5:0];
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    if (reg_req.read) begin
      next_st.rvalid = 1'b1;
      case (reg_req.addr)
        ADDR_IND_DATA_LO: next_st.rdata = st.ind_lo;
        ADDR_IND_DATA_HI: next_st.rdata = st.ind_hi;
        ADDR_IND_WRITE:   next_st.rdata = st.ind_addr;
        ADDR_RING_CFG:    next_st.rdata = st.cfg;
        ADDR_ON_LO:       next_st.rdata = st.on_period[7:0];
        ADDR_ON_HI:       next_st.rdata = st.on_period[15:8];
        ADDR_OFF_LO:      next_st.rdata = st.off_period[7:0];
        ADDR_OFF_HI:      next_st.rdata = st.off_period[15:8];
        ADDR_LINE_STATE:  next_st.rdata = {5'h00, st.lf};
        ADDR_HIGH_BATT:   next_st.rdata = {2'h0, st.batt};
        default:          next_st.rdata = 8'h00;
      endcase
    end

    // Waveform update.
    if (sine_step) begin
      next_st.y      = sine_next;
      next_st.y_prev = st.y;
    end
    if (trap_step) begin
      if (st.half_cnt + 16'h0001 >= st.phase_seed) begin
        next_st.half_cnt  = 16'h0000;
        next_st.ramp_down = ~st.ramp_down;
      end else begin
        next_st.half_cnt = st.half_cnt + 16'h0001;
      end
      if (st.ramp_down) begin
        next_st.y = (ramp_dn < neg_amp) ? neg_amp[15:0] : ramp_dn[15:0];
      end else begin
        next_st.y = (ramp_up > pos_amp) ? pos_amp[15:0] : ramp_up[15:0];
      end
    end

    // Cadence. A write of the ringing code is seen in the same cycle.
    ring_sel = (next_st.lf == LS_RING);
    case (st.phase)
      PH_IDLE: begin
        if (ring_sel) begin
          next_st.phase = PH_ON;
          next_st.cnt   = 16'h0000;
        end
      end
      PH_ON: begin
        if (!ring_sel) begin
          next_st.phase = PH_IDLE;
        end else if (on_expire) begin
          next_st.phase = PH_OFF;
          next_st.cnt   = 16'h0000;
        end else if (st.step_tick) begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      PH_OFF: begin
        if (!ring_sel) begin
          next_st.phase = PH_IDLE;
        end else if (off_expire) begin
          next_st.phase = PH_ON;
          next_st.cnt   = 16'h0000;
        end else if (st.step_tick) begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    // Each new ring restarts the oscillator, sine from its programmed seed and trapezoid from zero;
    // freq is read live, so a change to it acts on the next step, not at the next ring.
    if (next_st.phase == PH_ON && st.phase != PH_ON) begin
      next_st.y         = st.cfg[CFG_SHAPE] ? 16'h0000 : st.phase_seed;
      next_st.y_prev    = st.amp;
      next_st.half_cnt  = 16'h0000;
      next_st.ramp_down = 1'b0;
    end

    // Output sample: strobe rate follows the shape.
    if (st.cfg[CFG_SHAPE] ? st.step_tick : st.ms_tick) begin
      next_st.sample_valid = 1'b1;
      next_st.sample       = wave_now + offset_now;
    end

    case (next_st.phase)
      PH_ON:   next_st.line_state = LS_RING;
      PH_OFF:  next_st.line_state = LS_ONHOOK_TX;
      default: next_st.line_state = next_st.lf;
    endcase
    next_st.ringing = (next_st.phase == PH_ON);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata            = st.rdata;
  assign reg_rvalid           = st.rvalid;
  assign ring_sample          = st.sample;
  assign sample_valid         = st.sample_valid;
  assign ringing_active       = st.ringing;
  assign line_state           = st.line_state;
  assign cm_headroom          = st.headroom;
  assign high_battery_setting = st.batt;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ring_expiry;
    st.phase == PH_ON && on_expire && next_st.lf == LS_RING;
  endsequence

  sequence s_silent_entered;
    st.phase == PH_OFF && st.cnt == 16'h0000 &&
    st.line_state == LS_ONHOOK_TX && !st.ringing;
  endsequence

  sequence s_silence_expiry;
    st.phase == PH_OFF && off_expire && next_st.lf == LS_RING;
  endsequence

  sequence s_ring_entered;
    st.phase == PH_ON && st.cnt == 16'h0000 && st.ringing;
  endsequence

  chk_sine_rate: assert property (
    st.sample_valid && !$past(st.cfg[CFG_SHAPE]) |-> $past(st.ms_tick))
    else $error("sine sample outside the 1 ms strobe");

  chk_osc_shift: assert property (
    sine_step && !(next_st.phase == PH_ON && st.phase != PH_ON)
    |=> st.y_prev == $past(st.y))
    else $error("resonator history not shifted");

  chk_ring_enter: assert property (
    reg_req.write && reg_req.addr == ADDR_LINE_STATE &&
    reg_req.wdata[2:0] == LS_RING && st.phase == PH_IDLE
    |=> s_ring_entered ##0 line_state == LS_RING)
    else $error("ringing not entered on line state write");

  chk_ring_stop: assert property (
    s_ring_expiry |=> s_silent_entered)
    else $error("on period expiry did not silence the line");

  chk_ring_restart: assert property (
    s_silence_expiry |=> s_ring_entered)
    else $error("off period expiry did not restart ringing");

  chk_ring_leave: assert property (
    st.phase != PH_IDLE && next_st.lf != LS_RING
    |=> st.phase == PH_IDLE && !ringing_active)
    else $error("ringing continued without ringing line state");

  chk_cadence_step: assert property (
    $changed(st.cnt) && st.cnt != 16'h0000 |-> $past(st.step_tick))
    else $error("cadence count moved off the step tick");

  chk_offset_add: assert property (
    st.sample_valid |-> st.sample == 16'($past(wave_now) +
      ($past(st.cfg[CFG_OFFSET]) ? $past(st.bias) : 16'h0000)))
    else $error("dc offset applied against its enable");

  chk_trap_clamp: assert property (
    run && st.cfg[CFG_SHAPE] && $past(trap_step) |->
    $signed({st.y[15], st.y}) <= pos_amp &&
    $signed({st.y[15], st.y}) >= neg_amp)
    else $error("trapezoid left the amplitude band");

  chk_ind_write: assert property (
    reg_req.write && reg_req.addr == ADDR_IND_WRITE &&
    reg_req.wdata == IND_FREQ
    |=> st.freq == {$past(st.ind_hi), $past(st.ind_lo)})
    else $error("indirect write did not reach the coefficient");

endmodule : ringing_waveform_generator

/* File: sim/ring_line_model.sv */
`timescale 1ns/1ps
// ============================================================================
// Line side: counts every sample and keeps the deepest ringing level
// ============================================================================
module ring_line_model (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] ring_sample,
  input  wire logic        sample_valid,
  input  wire logic [2:0]  line_state,
  output logic      [15:0] sample_count,
  output logic      [15:0] peak_level
);
  // Only the ringing state puts voltage on the line, so samples taken in
  // any other state are counted but never move the peak. A zero phase
  // seed starts the resonator on its negative half-wave, and a short ring
  // may never reach the positive one, so the negative peak is kept.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_count <= '0;
      peak_level   <= '0;
    end else if (sample_valid) begin
      sample_count <= sample_count + 16'h0001;
      if (line_state == 3'h4 && $signed(ring_sample) < $signed(peak_level))
        peak_level <= ring_sample;
    end
  end
endmodule : ring_line_model

/* File: sim/ringing_waveform_generator_tb_top.sv */
`timescale 1ns/1ps
module ringing_waveform_generator_tb_top;
  import ring_gen_pkg::*;
  // ==========================================================================
  // Settings and signals
  // ==========================================================================
  // Short dividers keep the cadence runs under 250 cycles each.
  localparam int STEP  = 8;
  localparam int SAMP  = 64;
  localparam int ON_P  = 30;
  localparam int OFF_P = 9;
  localparam int LIMIT = 20000;
  logic        ref_clk;
  logic        reset_n;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [15:0] ring_sample;
  logic        sample_valid;
  logic        ringing_active;
  logic [2:0]  line_state;
  logic [3:0]  cm_headroom;
  logic [5:0]  high_battery_setting;
  logic [15:0] sample_count;
  logic [15:0] peak_level;
  int          fails;
  int          total_checks;
  int          cycles;

  ringing_waveform_generator #(.STEP_DIV(STEP), .SAMPLE_DIV(SAMP)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ring_sample(ring_sample), .sample_valid(sample_valid),
    .ringing_active(ringing_active), .line_state(line_state),
    .cm_headroom(cm_headroom),
    .high_battery_setting(high_battery_setting));

  ring_line_model line_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .ring_sample(ring_sample),
    .sample_valid(sample_valid), .line_state(line_state),
    .sample_count(sample_count), .peak_level(peak_level));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // The strobe drops on the edge that takes it, so the next call always
  // starts one clean edge later.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge ref_clk);
    reg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check({what, " valid"}, reg_rvalid, 1'b1);
    check(what, reg_rdata, exp);
  endtask : rd

  task automatic ind_wr(input logic [7:0] a, input logic [15:0] d);
    wr(ADDR_IND_DATA_LO, d[7:0]);
    wr(ADDR_IND_DATA_HI, d[15:8]);
    wr(ADDR_IND_WRITE, a);
  endtask : ind_wr

  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (sample_valid !== 1'b1 && n < 2000);
  endtask : wait_valid

  task automatic wait_ring(input logic v, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (ringing_active !== v && n < 2000);
  endtask : wait_ring

  function automatic logic [15:0] reson(input logic [15:0] f, s1, s0);
    logic signed [31:0] p;
    p = $signed(f) * $signed(s1);
    return p[29:14] - s0;
  endfunction : reson

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    wr(ADDR_RING_CFG, 8'h1A);
    rd(ADDR_RING_CFG, 8'h1A, "config");
    wr(ADDR_HIGH_BATT, 8'h2A);
    rd(ADDR_HIGH_BATT, 8'h2A, "battery");
    check("battery out", high_battery_setting, 6'h2A);
    rd(8'h05, 8'h00, "unmapped");
    wr(ADDR_ON_HI, 8'h7F);
    rd(ADDR_ON_HI, 8'h7F, "on hi");
    ind_wr(IND_HEADROOM, 16'h000F);
    check("headroom", cm_headroom, 4'hF);
    ind_wr(IND_AMPLITUDE, 16'h0177);
    wr(ADDR_IND_READ, IND_AMPLITUDE);
    rd(ADDR_IND_DATA_LO, 8'h77, "ind lo");
    rd(ADDR_IND_DATA_HI, 8'h01, "ind hi");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_cadence;
    logic [15:0] s[3];
    int n;
    int m;
    // A 20 Hz sine near 70 V peak, well above the open-circuit setting.
    ind_wr(IND_FREQ, 16'h7EFD);
    ind_wr(IND_AMPLITUDE, 16'h0177);
    ind_wr(IND_PHASE, 16'h0000);
    ind_wr(IND_DC_BIAS, 16'h0123);
    wr(ADDR_ON_LO, 8'(ON_P));
    wr(ADDR_ON_HI, 8'h00);
    wr(ADDR_OFF_LO, 8'(OFF_P));
    wr(ADDR_OFF_HI, 8'h00);
    wr(ADDR_RING_CFG, 8'h1E);
    wr(ADDR_LINE_STATE, 8'h04);
    check("ring start", ringing_active, 1'b1);
    check("ring state", line_state, LS_RING);
    for (int i = 0; i < 3; i++) begin
      wait_valid(n);
      s[i] = ring_sample - 16'h0123;
      if (i > 0) check("sample gap", n, SAMP);
    end
    check("resonator", s[2], reson(16'h7EFD, s[1], s[0]));
    wait_ring(1'b0, n);
    check("off state", line_state, LS_ONHOOK_TX);
    wait_valid(n);
    check("offset only", ring_sample, 16'h0123);
    wait_ring(1'b1, m);
    check("off length", n + m, (OFF_P + 1) * STEP);
    check("restart state", line_state, LS_RING);
    wait_ring(1'b0, n);
    check("on length", n, (ON_P + 1) * STEP);
    // First resonator step from a zero seed lands on minus the amplitude.
    check("line peak",
          $signed(peak_level) <= $signed(16'h0123 - 16'h0177), 1'b1);
    wr(ADDR_LINE_STATE, 8'h00);
    @(posedge ref_clk);
    #1;
    check("idle state", line_state, 3'h0);
    repeat ((OFF_P + 2) * STEP) @(posedge ref_clk);
    #1;
    check("no restart", ringing_active, 1'b0);
    $display("t_cadence done");
  endtask : t_cadence

  task automatic t_trap;
    logic [15:0] s0;
    logic [15:0] c0;
    int n;
    ind_wr(IND_FREQ, 16'h0010);
    ind_wr(IND_AMPLITUDE, 16'h0100);
    ind_wr(IND_PHASE, 16'h0040);
    wr(ADDR_RING_CFG, 8'h05);
    wr(ADDR_LINE_STATE, 8'h04);
    wait_valid(n);
    s0 = ring_sample;
    c0 = sample_count;
    wait_valid(n);
    check("ramp gap", n, STEP);
    check("line count", sample_count - c0, 16'h0001);
    check("ramp step", ring_sample - s0, 16'h0010);
    wr(ADDR_LINE_STATE, 8'h00);
    @(posedge ref_clk);
    #1;
    check("stop in on", ringing_active, 1'b0);
    $display("t_trap done");
  endtask : t_trap

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    check("reset active", ringing_active, 1'b0);
    check("reset state", line_state, 3'h0);
    t_regs();
    t_cadence();
    t_trap();
    close_out();
  end
endmodule : ringing_waveform_generator_tb_top
